// >>> sgo_pkg.sv
// constants for the sample gain and offset correction block
package sgo_pkg;
  localparam int SGO_AW = 6;
  localparam logic [5:0] SGO_CTRL = 6'h00;
  localparam logic [5:0] SGO_STATUS = 6'h04;
  localparam logic [5:0] SGO_IRQ_STAT = 6'h08;
  localparam logic [5:0] SGO_IRQ_MASK = 6'h0c;
  localparam logic [5:0] SGO_GO_GAIN = 6'h10;
  localparam logic [5:0] SGO_GO_OFF = 6'h14;
  localparam logic [5:0] SGO_GO_CMD = 6'h18;
  localparam logic [5:0] SGO_CAL_GAIN0 = 6'h20;
  localparam logic [5:0] SGO_CAL_OFF0 = 6'h24;
  localparam logic [5:0] SGO_CAL_GAIN1 = 6'h28;
  localparam logic [5:0] SGO_CAL_OFF1 = 6'h2c;
  localparam logic [5:0] SGO_BIAS = 6'h30;
  localparam logic [5:0] SGO_BASE_TGT = 6'h34;
  localparam logic [5:0] SGO_IL_TRIM = 6'h38;
  // control bits
  localparam int SGO_C_SWITCH = 0;
  localparam int SGO_C_STAB = 1;
  localparam int SGO_C_BYPASS = 2;
  localparam int SGO_C_EST = 3;
  localparam logic [3:0] SGO_CTRL_RST = 4'h4;
  // command argument fields
  localparam int SGO_CMD_OVR = 7;
  localparam int SGO_CMD_CH = 1;
  // interrupt bits
  localparam int SGO_I_OVF0 = 0;
  localparam int SGO_I_OVF1 = 1;
  localparam int SGO_I_BIAS = 2;
  localparam int SGO_I_CONF = 3;
  // arithmetic and bus response codes
  localparam int SGO_FRAC = 10;
  localparam logic [15:0] SGO_UNITY = 16'h0400;
  localparam logic [15:0] SGO_CAL_GAIN_RST = 16'h0400;
  localparam logic [15:0] SGO_CAL_OFF_RST = 16'h0000;
  localparam logic [15:0] SGO_TRIM_RST = 16'h0000;
  localparam logic [15:0] SGO_MAXP = 16'h7fff;
  localparam logic [15:0] SGO_MAXN = 16'h8000;
  localparam int SGO_EST_W = 22;
  localparam int SGO_EST_SH = 6;
  localparam int SGO_LAT = 3;
  localparam logic [1:0] SGO_OKAY = 2'h0;
  localparam logic [1:0] SGO_SLVERR = 2'h2;
endpackage

// >>> sgo_lane.sv
// one correction lane: two gain stages, offset, saturation
`timescale 1ns/100ps
module sgo_lane
  import sgo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic inValid,
  input wire logic [15:0] inSample,
  input wire logic [15:0] gainA,
  input wire logic [15:0] gainB,
  input wire logic [17:0] offSum,
  output logic outValid,
  output logic [15:0] outSample,
  output logic outOvf
);
  typedef struct packed {
    logic v1;
    logic [22:0] m1;
    logic [15:0] gB;
    logic [17:0] off;
    logic v2;
    logic [30:0] sum;
    logic v3;
    logic [15:0] out;
    logic ovf;
  } sgo_lane_s;
  sgo_lane_s s_reg, s_next;
  logic signed [32:0] p1;
  logic signed [39:0] p2;
  logic signed [30:0] sum;

  always_comb begin
    s_next = s_reg;
    // RULE17: gain over 1024
    p1 = $signed(inSample) * $signed({1'b0, gainA});
    p2 = $signed(s_reg.m1) * $signed({1'b0, s_reg.gB});
    // RULE1: gain then offset
    sum = $signed({p2[39], p2[39:10]}) - $signed({{13{s_reg.off[17]}}, s_reg.off});
    // RULE19: fixed three stages
    s_next.v1 = inValid;
    s_next.m1 = p1[32:SGO_FRAC];
    s_next.gB = gainB;
    s_next.off = offSum;
    s_next.v2 = s_reg.v1;
    s_next.sum = sum;
    s_next.v3 = s_reg.v2;
    // RULE18: saturate and flag
    s_next.ovf = s_reg.v2 && ($signed(s_reg.sum) > 31'sd32767 || $signed(s_reg.sum) < -31'sd32768);
    if ($signed(s_reg.sum) > 31'sd32767) begin
      s_next.out = SGO_MAXP;
    end else if ($signed(s_reg.sum) < -31'sd32768) begin
      s_next.out = SGO_MAXN;
    end else begin
      s_next.out = s_reg.sum[15:0];
    end
    if (!rst_b) begin
      s_next = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  assign outValid = s_reg.v3;
  assign outSample = s_reg.out;
  assign outOvf = s_reg.ovf;
endmodule // sgo_lane

// >>> sgo_top.sv
// correction datapath, front-end controls and register slave
// What this block does
// RULE1: default output is raw times calibration gain minus calibration offset
// RULE2: normal mode applies calibration and user gain, then both offsets
// RULE3: bit 7 of channel argument drops calibration, uses user values only
// RULE4: override with user gain 1024 and offset 0 passes raw sample
// RULE5: user values act on calibrated result or on raw sample
// RULE6: bias code is signed 16 bit, maps onto half ranges
// RULE7: software derives bias code from voltage over half range times 2^15
// RULE8: software waits one second after a bias change
// RULE9: two lanes at 5 GSPS or one channel at 10 GSPS
// RULE10: input switch only connects input, never changes channel mode
// RULE11: baseline stabilizer off after reset until software enables it
// RULE12: software enables stabilizer while input is quiet
// RULE13: stabilizer tracks drift, locks to target, 22 bit precision
// RULE14: interleave corrector holds factory trims, bypassed until changed
// RULE15: interleave corrector trims gain and offset between cores
// RULE16: software never enables stabilizer and interleave corrector together
// RULE17: gain setting divided by 1024 is the multiplier
// RULE18: overflow saturates to 32767 or -32768 and flags it
// RULE19: one sample per clock per lane, fixed latency, no rounding
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module sgo_top
  import sgo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [sgo_pkg::SGO_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sgo_pkg::SGO_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic modeStrap,
  input wire logic inValid0,
  input wire logic [15:0] inSample0,
  input wire logic inValid1,
  input wire logic [15:0] inSample1,
  output logic outValid0,
  output logic [15:0] outSample0,
  output logic outOvf0,
  output logic outValid1,
  output logic [15:0] outSample1,
  output logic outOvf1,
  output logic inputConnect,
  output logic [15:0] bias_code,
  output logic baselineStabilizerOn,
  output logic interleaveCorrectorBypass,
  output logic interleaveEstimationSelect,
  output logic dualMode,
  output logic irq
);
  typedef struct packed {
    logic awGot;
    logic [5:0] awAddr;
    logic wGot;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic [3:0] ctrl;
    logic [3:0] irqStat;
    logic [3:0] irqMask;
    logic irq;
    logic [15:0] goGain;
    logic [15:0] goOff;
    logic [1:0][15:0] calGain;
    logic [1:0][15:0] calOff;
    logic [1:0][15:0] userGain;
    logic [1:0][15:0] userOff;
    logic [1:0] ovrd;
    logic [15:0] bias;
    logic [15:0] baseTgt;
    logic [15:0] trim;
    logic [21:0] est;
    logic strap1;
    logic strap2;
    logic strapDone;
    logic dual;
  } sgo_top_s;
  sgo_top_s s_reg, s_next;
  logic [1:0] laneValid;
  logic [1:0][15:0] laneOut;
  logic [1:0] laneOvf;
  logic [1:0][15:0] gA;
  logic [1:0][15:0] gB;
  logic [1:0][17:0] offSum;
  logic [1:0] inV;
  logic [1:0][15:0] inS;
  logic [16:0] stabCorr;

  function automatic logic [31:0] sgo_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        old[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return old;
  endfunction

  function automatic logic sgo_mapped(input logic [5:0] a);
    case (a)
      SGO_CTRL, SGO_STATUS, SGO_IRQ_STAT, SGO_IRQ_MASK, SGO_GO_GAIN, SGO_GO_OFF, SGO_GO_CMD,
      SGO_CAL_GAIN0, SGO_CAL_OFF0, SGO_CAL_GAIN1, SGO_CAL_OFF1, SGO_BIAS, SGO_BASE_TGT,
      SGO_IL_TRIM: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  assign inV = {inValid1, inValid0};
  assign inS = {inSample1, inSample0};

  always_comb begin
    logic [31:0] rd;
    logic [31:0] wv;
    logic [3:0] evt;
    logic [3:0] clr;
    logic [22:0] diff;
    logic idx;
    rd = '0;
    wv = '0;
    evt = '0;
    clr = '0;
    diff = '0;
    idx = 1'b0;
    s_next = s_reg;
    // RULE13: leaky baseline estimate, target lock
    stabCorr = {s_reg.est[21], s_reg.est[21:SGO_EST_SH]} - {s_reg.baseTgt[15], s_reg.baseTgt};
    for (int i = 0; i < 2; i++) begin
      // RULE9: single channel shares channel 0 settings
      idx = (i == 1) && s_reg.dual;
      // RULE3: override drops calibration
      gA[i] = s_reg.ovrd[idx] ? SGO_UNITY : s_reg.calGain[idx];
      offSum[i] = {{2{s_reg.userOff[idx][15]}}, s_reg.userOff[idx]};
      // RULE2: both offsets in normal mode
      if (!s_reg.ovrd[idx]) begin
        offSum[i] = offSum[i] + {{2{s_reg.calOff[idx][15]}}, s_reg.calOff[idx]};
      end
      // RULE15: odd core trim when corrector active
      if (i == 1 && !s_reg.ctrl[SGO_C_BYPASS]) begin
        gA[i] = gA[i] + {{8{s_reg.trim[7]}}, s_reg.trim[7:0]};
        offSum[i] = offSum[i] + {{10{s_reg.trim[15]}}, s_reg.trim[15:8]};
      end
      if (s_reg.ctrl[SGO_C_STAB]) begin
        offSum[i] = offSum[i] + {stabCorr[16], stabCorr};
      end
      // RULE5: user gain on calibrated or raw value
      gB[i] = s_reg.userGain[idx];
    end
    if (s_reg.ctrl[SGO_C_STAB] && laneValid[0]) begin
      diff = {laneOut[0][15], laneOut[0], {SGO_EST_SH{1'b0}}} - {s_reg.est[21], s_reg.est};
      s_next.est = s_reg.est + SGO_EST_W'($signed(diff) >>> SGO_EST_SH);
    end else if (!s_reg.ctrl[SGO_C_STAB]) begin
      s_next.est = '0;
    end
    // RULE10: mode caught once after reset
    s_next.strap1 = modeStrap;
    s_next.strap2 = s_reg.strap1;
    if (!s_reg.strapDone) begin
      s_next.dual = s_reg.strap2;
      s_next.strapDone = 1'b1;
    end
    // write channels
    if (s_axi_awvalid && s_reg.awReady) begin
      s_next.awGot = 1'b1;
      s_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wReady) begin
      s_next.wGot = 1'b1;
      s_next.wData = s_axi_wdata;
      s_next.wStrb = s_axi_wstrb;
    end
    if (s_reg.bValid && s_axi_bready) begin
      s_next.bValid = 1'b0;
    end
    if (s_reg.awGot && s_reg.wGot && !s_reg.bValid) begin
      s_next.awGot = 1'b0;
      s_next.wGot = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp = sgo_mapped(s_reg.awAddr) ? SGO_OKAY : SGO_SLVERR;
      case (s_reg.awAddr)
        SGO_CTRL: begin
          wv = sgo_merge({28'h0, s_reg.ctrl}, s_reg.wData, s_reg.wStrb);
          s_next.ctrl = wv[3:0];
        end
        SGO_IRQ_STAT: begin
          wv = sgo_merge(32'h0, s_reg.wData, s_reg.wStrb);
          clr = wv[3:0];
        end
        SGO_IRQ_MASK: begin
          wv = sgo_merge({28'h0, s_reg.irqMask}, s_reg.wData, s_reg.wStrb);
          s_next.irqMask = wv[3:0];
        end
        SGO_GO_GAIN: begin
          wv = sgo_merge({16'h0, s_reg.goGain}, s_reg.wData, s_reg.wStrb);
          s_next.goGain = wv[15:0];
        end
        SGO_GO_OFF: begin
          wv = sgo_merge({16'h0, s_reg.goOff}, s_reg.wData, s_reg.wStrb);
          s_next.goOff = wv[15:0];
        end
        // RULE4: command latches staged gain and offset
        SGO_GO_CMD: begin
          idx = s_reg.wData[SGO_CMD_CH];
          s_next.userGain[idx] = s_reg.goGain;
          s_next.userOff[idx] = s_reg.goOff;
          s_next.ovrd[idx] = s_reg.wData[SGO_CMD_OVR];
        end
        SGO_CAL_GAIN0: s_next.calGain[0] = s_reg.wData[15:0];
        SGO_CAL_OFF0: s_next.calOff[0] = s_reg.wData[15:0];
        SGO_CAL_GAIN1: s_next.calGain[1] = s_reg.wData[15:0];
        SGO_CAL_OFF1: s_next.calOff[1] = s_reg.wData[15:0];
        // RULE6: signed bias code register
        SGO_BIAS: begin
          wv = sgo_merge({16'h0, s_reg.bias}, s_reg.wData, s_reg.wStrb);
          s_next.bias = wv[15:0];
          evt[SGO_I_BIAS] = 1'b1;
        end
        SGO_BASE_TGT: s_next.baseTgt = s_reg.wData[15:0];
        SGO_IL_TRIM: s_next.trim = s_reg.wData[15:0];
        default: wv = '0;
      endcase
    end
    s_next.awReady = !s_next.awGot && !s_next.bValid;
    s_next.wReady = !s_next.wGot && !s_next.bValid;
    // read channel
    case (s_axi_araddr)
      SGO_CTRL: rd = {28'h0, s_reg.ctrl};
      SGO_STATUS: rd = {29'h0, s_reg.dual, s_reg.ovrd};
      SGO_IRQ_STAT: rd = {28'h0, s_reg.irqStat};
      SGO_IRQ_MASK: rd = {28'h0, s_reg.irqMask};
      SGO_GO_GAIN: rd = {16'h0, s_reg.goGain};
      SGO_GO_OFF: rd = {16'h0, s_reg.goOff};
      SGO_CAL_GAIN0: rd = {16'h0, s_reg.calGain[0]};
      SGO_CAL_OFF0: rd = {16'h0, s_reg.calOff[0]};
      SGO_CAL_GAIN1: rd = {16'h0, s_reg.calGain[1]};
      SGO_CAL_OFF1: rd = {16'h0, s_reg.calOff[1]};
      SGO_BIAS: rd = {16'h0, s_reg.bias};
      SGO_BASE_TGT: rd = {16'h0, s_reg.baseTgt};
      SGO_IL_TRIM: rd = {16'h0, s_reg.trim};
      default: rd = '0;
    endcase
    if (s_reg.rValid && s_axi_rready) begin
      s_next.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arReady) begin
      s_next.rValid = 1'b1;
      s_next.rData = rd;
      s_next.rResp = sgo_mapped(s_axi_araddr) ? SGO_OKAY : SGO_SLVERR;
    end
    s_next.arReady = !s_next.rValid;
    // RULE18: overflow events
    evt[SGO_I_OVF0] = laneOvf[0];
    evt[SGO_I_OVF1] = laneOvf[1];
    // RULE16: flag both enhancements on together
    evt[SGO_I_CONF] = s_reg.ctrl[SGO_C_STAB] && !s_reg.ctrl[SGO_C_BYPASS];
    s_next.irqStat = (s_reg.irqStat & ~clr) | evt;
    s_next.irq = |(s_reg.irqStat & s_reg.irqMask);
    if (!rst_b) begin
      s_next = '0;
      // strap synchroniser keeps running through reset
      s_next.strap1 = modeStrap;
      s_next.strap2 = s_reg.strap1;
      // RULE11: stabilizer off, RULE14: corrector bypassed
      s_next.ctrl = SGO_CTRL_RST;
      s_next.calGain = {SGO_CAL_GAIN_RST, SGO_CAL_GAIN_RST};
      s_next.calOff = {SGO_CAL_OFF_RST, SGO_CAL_OFF_RST};
      s_next.trim = SGO_TRIM_RST;
      // RULE1: user defaults give calibration only
      s_next.userGain = {SGO_UNITY, SGO_UNITY};
      s_next.goGain = SGO_UNITY;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  for (genvar g = 0; g < 2; g++) begin : g_lane
    sgo_lane u_lane (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .inValid(inV[g]),
      .inSample(inS[g]),
      .gainA(gA[g]),
      .gainB(gB[g]),
      .offSum(offSum[g]),
      .outValid(laneValid[g]),
      .outSample(laneOut[g]),
      .outOvf(laneOvf[g])
    );
  end

  assign outValid0 = laneValid[0];
  assign outSample0 = laneOut[0];
  assign outOvf0 = laneOvf[0];
  assign outValid1 = laneValid[1];
  assign outSample1 = laneOut[1];
  assign outOvf1 = laneOvf[1];
  assign s_axi_awready = s_reg.awReady;
  assign s_axi_wready = s_reg.wReady;
  assign s_axi_bvalid = s_reg.bValid;
  assign s_axi_bresp = s_reg.bResp;
  assign s_axi_arready = s_reg.arReady;
  assign s_axi_rvalid = s_reg.rValid;
  assign s_axi_rdata = s_reg.rData;
  assign s_axi_rresp = s_reg.rResp;
  assign inputConnect = s_reg.ctrl[SGO_C_SWITCH];
  assign bias_code = s_reg.bias;
  assign baselineStabilizerOn = s_reg.ctrl[SGO_C_STAB];
  assign interleaveCorrectorBypass = s_reg.ctrl[SGO_C_BYPASS];
  assign interleaveEstimationSelect = s_reg.ctrl[SGO_C_EST];
  assign dualMode = s_reg.dual;
  assign irq = s_reg.irq;

  a_raw_passthru: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE4
    inValid0 && s_reg.ovrd[0] && s_reg.userGain[0] == SGO_UNITY && s_reg.userOff[0] == 16'h0000
    && !s_reg.ctrl[SGO_C_STAB] && $stable(s_reg.ovrd) |-> ##3 outSample0 == $past(inSample0, 3))
    else $error("override unity did not pass raw sample");
  a_sat_value: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE18
    outOvf0 |-> outSample0 == SGO_MAXP || outSample0 == SGO_MAXN)
    else $error("overflow without saturated value");
  a_lane_latency: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE19
    inValid1 |-> ##3 outValid1)
    else $error("lane latency not three cycles");
  a_stab_reset: assert property (@(posedge sys_clk) // RULE11
    !rst_b |=> !baselineStabilizerOn)
    else $error("stabilizer on after reset");
  a_bypass_reset: assert property (@(posedge sys_clk) // RULE14
    !rst_b |=> interleaveCorrectorBypass)
    else $error("interleave corrector not bypassed after reset");
  a_mode_stable: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE10
    s_reg.strapDone |=> $stable(dualMode))
    else $error("channel mode changed after capture");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE18
    (|(s_reg.irqStat & s_reg.irqMask)) |=> irq)
    else $error("irq not raised for unmasked status");
  a_cal_default: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE1
    inValid0 && !s_reg.ovrd[0] && s_reg.userGain[0] == SGO_UNITY && s_reg.userOff[0] == 16'h0000
    && s_reg.calGain[0] == SGO_UNITY && s_reg.calOff[0] == 16'h0000 && !s_reg.ctrl[SGO_C_STAB]
    && $stable(s_reg.calGain) |-> ##3 outSample0 == $past(inSample0, 3))
    else $error("unity calibration altered sample");
  c_overflow: cover property (@(posedge sys_clk) disable iff (!rst_b) outOvf0);
  c_override: cover property (@(posedge sys_clk) disable iff (!rst_b) s_reg.ovrd[0] && outValid0);
  c_stab_run: cover property (@(posedge sys_clk) disable iff (!rst_b) baselineStabilizerOn && outValid0);
endmodule // sgo_top

// >>> sgo_adc_model.sv
// behavioural converter core feeding one correction lane
`timescale 1ns/100ps
module sgo_adc_model (
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [15:0] value,
  output logic inValid,
  output logic [15:0] inSample
);
  logic [15:0] lastReg = 16'h0000;
  assign inValid = fire;
  // idle bus scrambles so stale codes never look valid
  assign inSample = fire ? value : ~lastReg;
  always @(posedge sys_clk) begin
    lastReg <= inSample;
  end
endmodule // sgo_adc_model

// >>> sample_gain_offset_correction_bench.sv
// self-checking bench for the sample gain and offset correction block
`timescale 1ns/100ps
module sample_gain_offset_correction_bench;
  import sgo_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic fire = 1'b0;
  logic [15:0] val = 16'h0000;
  logic inValid0, inValid1, outValid0, outValid1, outOvf0, outOvf1, inputConnect;
  logic baselineStabilizerOn, interleaveCorrectorBypass, interleaveEstimationSelect, dualMode, irq;
  logic [15:0] inSample0, inSample1, outSample0, outSample1, bias_code;
  logic [16:0] q0[$], q1[$];
  int errCount = 0, nChecks = 0;
  logic [31:0] seed = 32'd64742;
  int cg = 1024, co = 0, ug = 1024, uo = 0;
  logic ovr = 1'b0;
  logic strap = 1'b1;

  always #5 sys_clk = ~sys_clk;

  sgo_adc_model u_adc0 (.sys_clk, .fire, .value(val), .inValid(inValid0), .inSample(inSample0));
  sgo_adc_model u_adc1 (.sys_clk, .fire, .value(val), .inValid(inValid1), .inSample(inSample1));
  sgo_top u_sgo_top (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .modeStrap(strap), .inValid0, .inSample0, .inValid1, .inSample1, .outValid0,
    .outSample0, .outOvf0, .outValid1, .outSample1, .outOvf1, .inputConnect, .bias_code,
    .baselineStabilizerOn, .interleaveCorrectorBypass, .interleaveEstimationSelect, .dualMode, .irq);

  function automatic logic [15:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  // lane0 reference arithmetic with floor shifts and clamping
  function automatic logic [16:0] expect0(input logic [15:0] raw);
    longint p;
    p = (longint'($signed(raw)) * (ovr ? 1024 : cg)) >>> 10;
    p = ((p * ug) >>> 10) - uo - (ovr ? 0 : co);
    if (p > 32767) return {1'b1, 16'h7fff};
    if (p < -32768) return {1'b1, 16'h8000};
    return {1'b0, p[15:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      k++;
    end while (s_axi_bvalid !== 1'b1 && k < 200);
    if (k >= 200) errCount++;
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 200);
    if (k >= 200) errCount++;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic send(input logic [15:0] raw);
    q0.push_back(expect0(raw));
    q1.push_back(strap ? {1'b0, raw} : expect0(raw));
    fire <= 1'b1;
    val <= raw;
    @(posedge sys_clk);
  endtask

  task automatic drain(input string name);
    fire <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(32'(q0.size() + q1.size()), 0);
    $display("test %s done", name);
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // result watcher pairs each output sample with the oldest note
  always @(posedge sys_clk) begin
    if (outValid0 === 1'b1) chk({outOvf0, outSample0}, (q0.size() > 0) ? q0.pop_front() : 'x);
    if (outValid1 === 1'b1) chk({outOvf1, outSample1}, (q1.size() > 0) ? q1.pop_front() : 'x);
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    errCount++;
    finishTest();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(interleaveCorrectorBypass, 1);
    chk(baselineStabilizerOn, 0);
    chk(dualMode, 1);
    rd(SGO_CTRL, 32'h4, SGO_OKAY);
    rd(6'h3c, 32'h0, SGO_SLVERR);
    wr(6'h3c, 32'h1, SGO_SLVERR);
    $display("test reset done");
    wr(SGO_CAL_GAIN0, 32'd1063, SGO_OKAY);
    wr(SGO_CAL_OFF0, 32'h0000fffc, SGO_OKAY);
    cg = 1063;
    co = -4;
    send(16'h0010);
    for (int i = 0; i < 8; i++) send(nxt());
    drain("calibrated");
    wr(SGO_GO_GAIN, 32'd1500, SGO_OKAY);
    wr(SGO_GO_OFF, 32'd7, SGO_OKAY);
    wr(SGO_GO_CMD, 32'h01, SGO_OKAY);
    ug = 1500;
    uo = 7;
    for (int i = 0; i < 8; i++) send(nxt());
    drain("normal");
    wr(SGO_GO_GAIN, 32'd1024, SGO_OKAY);
    wr(SGO_GO_OFF, 32'd0, SGO_OKAY);
    wr(SGO_GO_CMD, 32'h81, SGO_OKAY);
    ug = 1024;
    uo = 0;
    ovr = 1'b1;
    rd(SGO_STATUS, 32'h5, SGO_OKAY);
    for (int i = 0; i < 8; i++) send(nxt());
    drain("override");
    wr(SGO_IRQ_STAT, 32'hf, SGO_OKAY);
    wr(SGO_GO_GAIN, 32'h0000ffff, SGO_OKAY);
    wr(SGO_GO_CMD, 32'h01, SGO_OKAY);
    ug = 65535;
    ovr = 1'b0;
    send(16'h7ffc);
    send(16'h8000);
    drain("saturation");
    chk(irq, 0);
    rd(SGO_IRQ_STAT, 32'h1, SGO_OKAY);
    wr(SGO_IRQ_MASK, 32'h1, SGO_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1);
    wr(SGO_IRQ_STAT, 32'h1, SGO_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(irq, 0);
    wr(SGO_BIAS, 32'h00008000, SGO_OKAY);
    chk(bias_code, 16'h8000);
    wr(SGO_CTRL, 32'hf, SGO_OKAY);
    chk(inputConnect, 1);
    chk(dualMode, 1);
    chk(baselineStabilizerOn, 1);
    chk(interleaveEstimationSelect, 1);
    rd(SGO_IRQ_STAT, 32'h4, SGO_OKAY);
    $display("test controls done");
    strap <= 1'b0;
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    cg = 1024;
    co = 0;
    ug = 1024;
    uo = 0;
    ovr = 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(dualMode, 0);
    chk(interleaveCorrectorBypass, 1);
    chk(baselineStabilizerOn, 0);
    wr(SGO_CTRL, 32'h2, SGO_OKAY);
    chk(interleaveCorrectorBypass, 0);
    rd(SGO_IRQ_STAT, 32'h8, SGO_OKAY);
    wr(SGO_CTRL, 32'h4, SGO_OKAY);
    for (int i = 0; i < 4; i++) send(nxt());
    drain("single default");
    wr(SGO_GO_GAIN, 32'd2048, SGO_OKAY);
    wr(SGO_GO_CMD, 32'h01, SGO_OKAY);
    ug = 2048;
    for (int i = 0; i < 8; i++) send(nxt());
    drain("single channel");
    finishTest();
  end
endmodule // sample_gain_offset_correction_bench
